// [core/dspclk_regs.vh]
// constants for the dsp clock mode generator: field values, reset values and timing counts
`ifndef DSPCLK_REGS_VH
`define DSPCLK_REGS_VH

// ********************************************************************
// mode-select pin patterns (pin a, pin b, pin c)
// ********************************************************************
`define DSPCLK_PINS_DIV2_OSC_OFF 3'h0
`define DSPCLK_PINS_DIV4         3'h5
`define DSPCLK_PINS_DIV2         3'h7

// ********************************************************************
// clock mode register: multiplier in quarter steps, bits 5:2 integer, 1:0 fraction
// ********************************************************************
`define DSPCLK_MULT_W          6
`define DSPCLK_MULT_INT_LSB    2
`define DSPCLK_MULT_RESET      6'h04
`define DSPCLK_MULT_MIN        6'h04
`define DSPCLK_QUARTERS_PER_TICK 8'h04

// ********************************************************************
// output clock divide field: divide factor is field value plus one
// ********************************************************************
`define DSPCLK_DIVF_W          2
`define DSPCLK_DIVF_UNDIVIDED  2'h0
`define DSPCLK_DIVF_RESET      2'h3

// ********************************************************************
// reference divide limits (count minus one)
// ********************************************************************
`define DSPCLK_REF_LIMIT_DIV2  2'h1
`define DSPCLK_REF_LIMIT_DIV4  2'h3

// ********************************************************************
// timing: clock rate and lock interval
// ********************************************************************
`define DSPCLK_CLK_MHZ         10
`define DSPCLK_LOCK_TIME_US    30
`define DSPCLK_LOCK_CYCLES     (`DSPCLK_LOCK_TIME_US * `DSPCLK_CLK_MHZ)
`define DSPCLK_LOCK_W          9

`endif

// [core/dspclk_div.v]
// event divider: emits one pulse every (limit+1) input steps
`timescale 1ns/1ps

module dspclk_div #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  // control
  input  wire             clear,
  input  wire             step,
  input  wire [WIDTH-1:0] limit,
  // result
  output reg              tick
);

  reg [WIDTH-1:0] count;

  // counts steps only, never time, so a stalled source just holds its place
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (step) begin
      if (count >= limit) begin
        count <= {WIDTH{1'b0}};
        tick  <= 1'b1;
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

// [core/dspclk_gen.v]
// dsp clock mode generator: strap decode, divide and multiply modes, lock gating, output divider
`timescale 1ns/1ps
`include "dspclk_regs.vh"

// Overview of operation
// - pins 000: machine tick is reference divided by two, loop and oscillator off.
// - multiply mode: tick rate is reference times N, N 1..15.75 in quarter steps.
// - software may rewrite the multiplier after reset completes, except during the lock wait.
// - multiply ratio comes from the clock mode register contents.
// - after a multiplier change wait at most 30 us before the loop counts as locked.
// - output divide field 00 passes the machine clock undivided to the output pin.
// - after reset the output divide field selects divide by four.
// - fully static: no timeouts on the reference, any slow rate keeps state.
module dspclk_gen (
  // clock and reset
  input  wire                        clk_sys,
  input  wire                        arst_n,
  // reference clock and mode straps
  input  wire                        reference_clock_input,
  input  wire                        clock_mode_select_pin_a,
  input  wire                        clock_mode_select_pin_b,
  input  wire                        clock_mode_select_pin_c,
  // software control
  input  wire                        mult_write,
  input  wire [`DSPCLK_MULT_W-1:0]   mult_value,
  input  wire                        divf_write,
  input  wire [`DSPCLK_DIVF_W-1:0]   divf_value,
  // status
  output reg  [`DSPCLK_MULT_W-1:0]   clock_mode_register,
  output reg  [`DSPCLK_DIVF_W-1:0]   output_clock_divide_field,
  output reg                         pll_enable,
  output reg                         osc_enable,
  output reg                         pll_locked,
  output reg                         mode_ready,
  // clocks out
  output reg                         machine_tick,
  output wire                        machine_clock_output
);

  // ********************************************************************
  // states
  // ********************************************************************
  localparam ST_STRAP = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_LOCK  = 3'h4;

  // the count is worked out as an integer, then cut to the counter width on purpose
  localparam integer              LOCK_LAST_I = `DSPCLK_LOCK_CYCLES - 1;
  localparam [`DSPCLK_LOCK_W-1:0] LOCK_LAST   = LOCK_LAST_I[`DSPCLK_LOCK_W-1:0];

  reg  [2:0]                  state;
  reg  [2:0]                  next_state;
  reg                         ref_q;
  reg                         div_mode;
  reg  [1:0]                  ref_limit;
  reg  [7:0]                  credit;
  reg  [7:0]                  next_credit;
  reg  [`DSPCLK_LOCK_W-1:0]   lock_count;
  reg                         next_tick;
  wire                        ref_rise;
  wire                        ref_tick;
  wire [2:0]                  pins;
  wire                        mult_ok;

  assign pins     = {clock_mode_select_pin_a, clock_mode_select_pin_b, clock_mode_select_pin_c};
  assign ref_rise = reference_clock_input & ~ref_q;
  // a multiplier below one is not a legal setting and is ignored
  assign mult_ok  = mult_write && (mult_value >= `DSPCLK_MULT_MIN);

  // ********************************************************************
  // reference edge detect
  // ********************************************************************
  // edge counting rather than period timing keeps the block static
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= reference_clock_input;
    end
  end

  // ********************************************************************
  // mode state machine
  // ********************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_STRAP: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (mult_ok) begin
          next_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (lock_count == LOCK_LAST) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_STRAP;
      end
    endcase
  end

  // straps caught on the first edge after reset release, never in the reset branch
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state               <= ST_STRAP;
      div_mode            <= 1'b1;
      ref_limit           <= `DSPCLK_REF_LIMIT_DIV2;
      pll_enable          <= 1'b0;
      osc_enable          <= 1'b0;
      pll_locked          <= 1'b0;
      mode_ready          <= 1'b0;
      clock_mode_register <= `DSPCLK_MULT_RESET;
      lock_count          <= {`DSPCLK_LOCK_W{1'b0}};
    end else begin
      state <= next_state;
      if (state == ST_STRAP) begin
        mode_ready <= 1'b1;
        case (pins)
          `DSPCLK_PINS_DIV2_OSC_OFF: begin
            div_mode   <= 1'b1;
            ref_limit  <= `DSPCLK_REF_LIMIT_DIV2;
            pll_enable <= 1'b0;
            osc_enable <= 1'b0;
            pll_locked <= 1'b0;
          end
          `DSPCLK_PINS_DIV4: begin
            div_mode   <= 1'b1;
            ref_limit  <= `DSPCLK_REF_LIMIT_DIV4;
            pll_enable <= 1'b0;
            osc_enable <= 1'b1;
            pll_locked <= 1'b0;
          end
          `DSPCLK_PINS_DIV2: begin
            div_mode   <= 1'b1;
            ref_limit  <= `DSPCLK_REF_LIMIT_DIV2;
            pll_enable <= 1'b0;
            osc_enable <= 1'b1;
            pll_locked <= 1'b0;
          end
          default: begin
            // any other pattern starts in multiply mode at times one
            div_mode   <= 1'b0;
            pll_enable <= 1'b1;
            osc_enable <= 1'b1;
            pll_locked <= 1'b1;
          end
        endcase
      end else if (state == ST_RUN && mult_ok) begin
        // a new factor always enters multiply mode and restarts the lock wait
        clock_mode_register <= mult_value;
        div_mode            <= 1'b0;
        pll_enable          <= 1'b1;
        pll_locked          <= 1'b0;
        lock_count          <= {`DSPCLK_LOCK_W{1'b0}};
      end else if (state == ST_LOCK) begin
        // writes during lock are dropped; software polls pll_locked first
        if (lock_count == LOCK_LAST) begin
          pll_locked <= 1'b1;
        end else begin
          lock_count <= lock_count + {{(`DSPCLK_LOCK_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ********************************************************************
  // multiply mode: quarter-step credit accumulator
  // ********************************************************************
  // each reference edge earns N quarters, each machine tick spends four
  always @* begin
    next_credit = credit;
    if (state != ST_RUN || div_mode) begin
      next_credit = 8'h00;
    end else begin
      if (credit >= `DSPCLK_QUARTERS_PER_TICK) begin
        next_credit = credit - `DSPCLK_QUARTERS_PER_TICK;
      end
      if (ref_rise) begin
        // saturate: the machine rate cannot exceed one tick per system cycle
        if ({1'b0, next_credit} + {3'h0, clock_mode_register} > 9'h0ff) begin
          next_credit = 8'hff;
        end else begin
          next_credit = next_credit + {2'h0, clock_mode_register};
        end
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      credit <= 8'h00;
    end else begin
      credit <= next_credit;
    end
  end

  // ********************************************************************
  // reference divider for the divide modes
  // ********************************************************************
  dspclk_div #(
    .WIDTH (2)
  ) u_ref_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clear   (~div_mode | (state != ST_RUN)),
    .step    (ref_rise),
    .limit   (ref_limit),
    .tick    (ref_tick)
  );

  // ********************************************************************
  // machine tick, held off outside the run state
  // ********************************************************************
  always @* begin
    next_tick = 1'b0;
    if (state == ST_RUN) begin
      if (div_mode) begin
        next_tick = ref_tick;
      end else begin
        next_tick = (credit >= `DSPCLK_QUARTERS_PER_TICK);
      end
    end
  end

  // whole ticks only: gating at the state boundary cannot cut a pulse short
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      machine_tick <= 1'b0;
    end else begin
      machine_tick <= next_tick;
    end
  end

  // ********************************************************************
  // output clock divide field and output divider
  // ********************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      output_clock_divide_field <= `DSPCLK_DIVF_RESET;
    end else if (divf_write) begin
      output_clock_divide_field <= divf_value;
    end
  end

  // field 00 gives limit 0, so every machine tick reaches the pin
  dspclk_div #(
    .WIDTH (`DSPCLK_DIVF_W)
  ) u_out_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clear   (divf_write),
    .step    (machine_tick),
    .limit   (output_clock_divide_field),
    .tick    (machine_clock_output)
  );

endmodule

// [tb/dspclk_properties.sv]
// checker: port relations of the clock mode generator
`timescale 1ns/1ps
`include "dspclk_regs.vh"
module dspclk_properties (
  // clock, reset and reference
  input wire                      clk_sys,
  input wire                      arst_n,
  input wire                      reference_clock_input,
  // software control
  input wire                      mult_write,
  input wire [`DSPCLK_MULT_W-1:0] mult_value,
  input wire                      divf_write,
  // status and clocks
  input wire [`DSPCLK_MULT_W-1:0] clock_mode_register,
  input wire [`DSPCLK_DIVF_W-1:0] output_clock_divide_field,
  input wire                      pll_enable,
  input wire                      osc_enable,
  input wire                      pll_locked,
  input wire                      mode_ready,
  input wire                      machine_tick,
  input wire                      machine_clock_output
);
  // ********************************************************************
  // relations, all in the system clock domain
  // ********************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // an accepted multiplier write, then the bounded lock wait
  sequence s_take;
    mult_write && mode_ready && (mult_value >= 6'h04) && (pll_locked || !pll_enable);
  endsequence
  sequence s_relock;
    ##[1:301] pll_locked;
  endsequence
  property p_osc_off;
    mode_ready && !osc_enable |-> !pll_enable && !pll_locked;
  endproperty
  property p_div_nolock;
    mode_ready && !pll_enable |-> !pll_locked;
  endproperty
  property p_write;
    s_take |=> clock_mode_register == $past(mult_value) && pll_enable && !pll_locked;
  endproperty
  property p_lock;
    s_take ##1 !pll_locked |-> s_relock;
  endproperty
  // a tick launched before the write may still land, so the first lock cycle is skipped
  property p_gate;
    pll_enable && !pll_locked && $past(pll_enable && !pll_locked) |-> !machine_tick;
  endproperty
  property p_undiv;
    machine_tick && output_clock_divide_field == 2'h0 && !divf_write |=> machine_clock_output;
  endproperty
  property p_rst_vals;
    $rose(mode_ready) |-> clock_mode_register == `DSPCLK_MULT_RESET
      && output_clock_divide_field == `DSPCLK_DIVF_RESET;
  endproperty
  property p_static;
    mode_ready && !pll_enable && machine_tick |-> $past(reference_clock_input)
      || $past(reference_clock_input, 2) || $past(reference_clock_input, 3);
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator off while loop active");
  a_div_nolock: assert property (p_div_nolock)
    else $error("lock flag set in divide mode");
  a_write: assert property (p_write)
    else $error("multiplier write not taken");
  a_lock: assert property (p_lock)
    else $error("lock wait too long");
  a_gate: assert property (p_gate)
    else $error("machine tick during lock");
  a_undiv: assert property (p_undiv)
    else $error("output clock not undivided");
  a_rst_vals: assert property (p_rst_vals)
    else $error("wrong values after reset");
  a_static: assert property (p_static)
    else $error("tick without reference edge");
endmodule

// [tb/dspclk_refsrc.sv]
// partner: external reference clock source with a stop control
`timescale 1ns/1ps
module dspclk_refsrc (
  // control from the bench
  input wire        run,
  input wire [15:0] half_ns,
  // reference clock to the generator
  output reg        ref_clk
);
  // odd start offset keeps the reference unrelated in phase to the system clock
  initial begin
    ref_clk = 1'b0;
    #37;
    forever begin
      if (run) begin
        #(half_ns) ref_clk = ~ref_clk;
      end else begin
        ref_clk = 1'b0; // a stopped source parks low, as a halted oscillator would
        #10;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// testbench: strap modes, multiplier, output divide and stopped reference
`timescale 1ns/1ps
`include "dspclk_regs.vh"
module tb_top;
  // stimulus and observed ports
  reg          clk_sys;
  reg          arst_n;
  reg  [2:0]   strap;
  reg          mult_write;
  reg          divf_write;
  reg  [5:0]   wr_value;
  reg          ref_run;
  reg  [15:0]  ref_half;
  wire         reference_clock_input;
  wire [5:0]   clock_mode_register;
  wire [1:0]   output_clock_divide_field;
  wire         pll_enable;
  wire         osc_enable;
  wire         pll_locked;
  wire         mode_ready;
  wire         machine_tick;
  wire         machine_clock_output;
  integer      error_cnt;
  integer      checked;
  integer      cyc = 0;
  // ********************************************************************
  // design, partner and clock
  // ********************************************************************
  dspclk_gen DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .reference_clock_input(reference_clock_input), .clock_mode_select_pin_a(strap[2]),
    .clock_mode_select_pin_b(strap[1]), .clock_mode_select_pin_c(strap[0]),
    .mult_write(mult_write), .mult_value(wr_value), .divf_write(divf_write),
    .divf_value(wr_value[1:0]), .clock_mode_register(clock_mode_register),
    .output_clock_divide_field(output_clock_divide_field), .pll_enable(pll_enable),
    .osc_enable(osc_enable), .pll_locked(pll_locked), .mode_ready(mode_ready),
    .machine_tick(machine_tick), .machine_clock_output(machine_clock_output));
  dspclk_refsrc SRC (.run(ref_run), .half_ns(ref_half), .ref_clk(reference_clock_input));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard: the whole sequence needs about 11000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task chk(input integer got, input integer lo, input integer hi);
    begin
      checked = checked + 1;
      // an unknown count must fail, so the range test is compared against a known one
      if ((got >= lo && got <= hi) !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
    end
  endtask
  task chkv(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // straps are held through reset so the first edge after release sees them
  task do_reset(input [2:0] s);
    begin
      @(posedge clk_sys);
      arst_n <= 1'b0;
      strap <= s;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask
  task wr(input m, input [5:0] v);
    begin
      @(posedge clk_sys);
      mult_write <= m;
      divf_write <= !m;
      wr_value <= v;
      @(posedge clk_sys);
      mult_write <= 1'b0;
      divf_write <= 1'b0;
      #1;
    end
  endtask
  task cnt_win(input integer n, output integer nt, output integer no);
    begin
      nt = 0;
      no = 0;
      repeat (n) begin
        @(posedge clk_sys);
        #1;
        nt = nt + machine_tick;
        no = no + machine_clock_output;
      end
    end
  endtask
  // ********************************************************************
  // scenarios
  // ********************************************************************
  task t_straps;
    integer i, d, nt, no;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        d = (i == 1) ? 4 : 2;
        do_reset(i == 0 ? `DSPCLK_PINS_DIV2_OSC_OFF :
                 i == 1 ? `DSPCLK_PINS_DIV4 : `DSPCLK_PINS_DIV2);
        chkv(output_clock_divide_field, `DSPCLK_DIVF_RESET);
        chkv({osc_enable, pll_enable, pll_locked}, {i != 0, 2'b00});
        cnt_win(640, nt, no);
        chk(nt, 80 / d - 1, 80 / d + 1);
        chk(no, 20 / d - 1, 20 / d + 1);
      end
    end
  endtask
  task t_divf;
    integer v, nt, no;
    begin
      for (v = 0; v < 4; v = v + 1) begin
        wr(1'b0, v);
        chkv(output_clock_divide_field, v);
        cnt_win(640, nt, no);
        chk(no, 40 / (v + 1) - 1, 40 / (v + 1) + 1);
      end
    end
  endtask
  task t_static;
    integer nt, no;
    begin
      ref_run <= 1'b0;
      cnt_win(20, nt, no);
      cnt_win(2000, nt, no);
      chk(nt, 0, 0);
      ref_run <= 1'b1;
      cnt_win(640, nt, no);
      chk(nt, 39, 41);
      // leave divide mode by a write: times two, then gated lock, then twice the reference rate
      wr(1'b1, 6'h08);
      cnt_win(300, nt, no);
      chk(nt, 0, 0);
      chkv({pll_enable, pll_locked, clock_mode_register}, 8'hc8);
      cnt_win(640, nt, no);
      chk(nt, 158, 162);
    end
  endtask
  // multiplier 15, 3.5 and 1.25 in quarter units, reference period 16 cycles
  task t_mult;
    integer i, w, nt, no;
    reg [5:0] v;
    begin
      ref_half <= 16'd800;
      do_reset(3'h2);
      chkv({pll_enable, pll_locked}, 2'b11);
      for (i = 0; i < 3; i = i + 1) begin
        v = (i == 0) ? 6'h3c : (i == 1) ? 6'h0e : 6'h05;
        wr(1'b1, v);
        wr(1'b1, 6'h07);
        chkv(clock_mode_register, v);
        nt = 0;
        w = 2;
        while (pll_locked !== 1'b1 && w < 400) begin
          @(posedge clk_sys);
          #1;
          nt = nt + machine_tick;
          w = w + 1;
        end
        chk(w, 2, `DSPCLK_LOCK_CYCLES);
        chk(nt, 0, 0);
        wr(1'b1, 6'h03);
        chkv(clock_mode_register, v);
        cnt_win(640, nt, no);
        chk(nt, 39 * v / 4 - 1, 41 * v / 4 + 1);
      end
    end
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    arst_n = 1'b0;
    strap = 3'h0;
    mult_write = 1'b0;
    divf_write = 1'b0;
    wr_value = 6'h04;
    ref_run = 1'b1;
    ref_half = 16'd400;
    t_straps;
    t_divf;
    t_static;
    t_mult;
    results;
  end
endmodule
bind dspclk_gen dspclk_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n),
  .reference_clock_input(reference_clock_input), .mult_write(mult_write),
  .mult_value(mult_value), .divf_write(divf_write), .clock_mode_register(clock_mode_register),
  .output_clock_divide_field(output_clock_divide_field), .pll_enable(pll_enable),
  .osc_enable(osc_enable), .pll_locked(pll_locked), .mode_ready(mode_ready),
  .machine_tick(machine_tick), .machine_clock_output(machine_clock_output));
